// [rtl/aodt_consts.svh]
`ifndef AODT_CONSTS_SVH
`define AODT_CONSTS_SVH

// ****************************************************************
// Clock and field positions.
// ****************************************************************
`define AODT_CLK_PERIOD_NS 25
`define AODT_CYC_W 7
`define AODT_W_BIT 0
`define AODT_S_BIT 1
`define AODT_REG_MSB 5
`define AODT_REG_LSB 3
`define AODT_MOD_MSB 7
`define AODT_MOD_LSB 6
`define AODT_MOD_REG 2'h3

// ****************************************************************
// Opcodes and reg field codes.
// ****************************************************************
`define AODT_OPC_GRP3 7'h7b
`define AODT_OPC_AAA 8'h37
`define AODT_OPC_DAA 8'h27
`define AODT_OPC_AAS 8'h3f
`define AODT_OPC_DAS 8'h2f
`define AODT_OPC_IMMUL 6'h1a
`define AODT_OPC_SH_ONE 7'h68
`define AODT_OPC_SH_CL 7'h69
`define AODT_OPC_SH_CNT 7'h60
`define AODT_REG_NEGATE 3'h3
`define AODT_REG_UMUL 3'h4
`define AODT_REG_SMUL 3'h5
`define AODT_REG_UDIVIDE 3'h6
`define AODT_REG_SDIVIDE 3'h7

// ****************************************************************
// Cycle counts.
// ****************************************************************
`define AODT_NEG_REG 7'h03
`define AODT_NEG_MEM 7'h0a
`define AODT_AAA 7'h08
`define AODT_DAA 7'h04
`define AODT_AAS 7'h07
`define AODT_DAS 7'h04
`define AODT_UM_RB_MIN 7'h1a
`define AODT_UM_RB_MAX 7'h1c
`define AODT_UM_RW_MIN 7'h23
`define AODT_UM_RW_MAX 7'h25
`define AODT_UM_MB_MIN 7'h20
`define AODT_UM_MB_MAX 7'h22
`define AODT_UM_MW_MIN 7'h29
`define AODT_UM_MW_MAX 7'h2b
`define AODT_UM_MW_MAX8 7'h30
`define AODT_SM_RB_MIN 7'h19
`define AODT_SM_RB_MAX 7'h1c
`define AODT_SM_RW_MIN 7'h22
`define AODT_SM_RW_MAX 7'h25
`define AODT_SM_MB_MIN 7'h1f
`define AODT_SM_MB_MIN8 7'h20
`define AODT_SM_MB_MAX 7'h22
`define AODT_SM_MW_MIN 7'h28
`define AODT_SM_MW_MAX 7'h2b
`define AODT_SI_R_MIN 7'h16
`define AODT_SI_R_MAX 7'h19
`define AODT_SI_M_MIN 7'h1d
`define AODT_SI_M_MAX 7'h20
`define AODT_UD_RB 7'h1d
`define AODT_UD_RW 7'h26
`define AODT_UD_MB 7'h23
`define AODT_UD_MW 7'h2c
`define AODT_SD_RB_MIN 7'h2c
`define AODT_SD_RB_MAX 7'h34
`define AODT_SD_RW_MIN 7'h35
`define AODT_SD_RW_MAX 7'h3d
`define AODT_SD_MB_MIN 7'h32
`define AODT_SD_MB_MAX 7'h3a
`define AODT_SD_MW_MIN 7'h3b
`define AODT_SD_MW_MAX 7'h43
`define AODT_XFER_EXTRA 7'h04
`define AODT_ONE 7'h01

`endif

// [rtl/aodt_pkg.sv]
package aodt_pkg;

    typedef enum logic [3:0] {
        op_none,
        op_negate_operand,
        op_ascii_adjust_after_add,
        op_decimal_adjust_after_add,
        op_ascii_adjust_after_sub,
        op_decimal_adjust_after_sub,
        op_unsigned_multiply,
        op_signed_multiply,
        op_signed_multiply_imm,
        op_unsigned_divide,
        op_signed_divide,
        op_shift_rotate
    } aodt_op_t;

    typedef enum logic [2:0] {
        sh_none,
        sh_rotate_left,
        sh_rotate_right,
        sh_rotate_carry_left,
        sh_rotate_carry_right,
        sh_shift_left,
        sh_shift_right_logic,
        sh_shift_right_arith
    } aodt_shift_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] modrm;
    } aodt_instr_t;

    typedef struct packed {
        aodt_op_t op;
        aodt_shift_t shift;
        logic word;
        logic mem;
        logic has_modrm;
        logic [1:0] imm_bytes;
        logic illegal;
    } aodt_decode_t;

    typedef struct packed {
        logic [6:0] min;
        logic [6:0] max;
    } aodt_timing_t;

endpackage

// [rtl/aodt_cycle_table.sv]
`timescale 1ns/10ps
`include "aodt_consts.svh"

module aodt_cycle_table (
    input wire aodt_pkg::aodt_decode_t i_decode,
    input wire logic i_bus8,
    output aodt_pkg::aodt_timing_t o_timing
);

    function automatic logic [6:0] pick(
        input logic word,
        input logic mem,
        input logic [6:0] rb,
        input logic [6:0] rw,
        input logic [6:0] mb,
        input logic [6:0] mw
    );
        logic [1:0] sel;
        sel = {mem, word};
        unique case (sel)
            2'h0: pick = rb;
            2'h1: pick = rw;
            2'h2: pick = mb;
            2'h3: pick = mw;
        endcase
    endfunction

    logic w;
    logic m;
    logic [6:0] extra;

    assign w = i_decode.word;
    assign m = i_decode.mem;

    always_comb begin
        extra = 7'h00;
        o_timing.min = `AODT_ONE;
        o_timing.max = `AODT_ONE;
        unique case (i_decode.op)
            aodt_pkg::op_negate_operand: begin
                // Read and write of a word on the byte bus.
                extra = (w && m && i_bus8) ? (`AODT_XFER_EXTRA << 1) : 7'h00;
                o_timing.min = (m ? `AODT_NEG_MEM : `AODT_NEG_REG) + extra;
                o_timing.max = o_timing.min;
            end
            aodt_pkg::op_ascii_adjust_after_add: begin
                o_timing.min = `AODT_AAA;
                o_timing.max = `AODT_AAA;
            end
            aodt_pkg::op_decimal_adjust_after_add: begin
                o_timing.min = `AODT_DAA;
                o_timing.max = `AODT_DAA;
            end
            aodt_pkg::op_ascii_adjust_after_sub: begin
                o_timing.min = `AODT_AAS;
                o_timing.max = `AODT_AAS;
            end
            aodt_pkg::op_decimal_adjust_after_sub: begin
                o_timing.min = `AODT_DAS;
                o_timing.max = `AODT_DAS;
            end
            aodt_pkg::op_unsigned_multiply: begin
                o_timing.min = pick(w, m, `AODT_UM_RB_MIN, `AODT_UM_RW_MIN,
                    `AODT_UM_MB_MIN, `AODT_UM_MW_MIN);
                o_timing.max = pick(w, m, `AODT_UM_RB_MAX, `AODT_UM_RW_MAX,
                    `AODT_UM_MB_MAX,
                    i_bus8 ? `AODT_UM_MW_MAX8 : `AODT_UM_MW_MAX);
            end
            aodt_pkg::op_signed_multiply: begin
                o_timing.min = pick(w, m, `AODT_SM_RB_MIN, `AODT_SM_RW_MIN,
                    i_bus8 ? `AODT_SM_MB_MIN8 : `AODT_SM_MB_MIN,
                    `AODT_SM_MW_MIN);
                o_timing.max = pick(w, m, `AODT_SM_RB_MAX, `AODT_SM_RW_MAX,
                    `AODT_SM_MB_MAX, `AODT_SM_MW_MAX);
            end
            aodt_pkg::op_signed_multiply_imm: begin
                extra = (m && i_bus8) ? `AODT_XFER_EXTRA : 7'h00;
                o_timing.min = (m ? `AODT_SI_M_MIN : `AODT_SI_R_MIN) + extra;
                o_timing.max = (m ? `AODT_SI_M_MAX : `AODT_SI_R_MAX) + extra;
            end
            aodt_pkg::op_unsigned_divide: begin
                o_timing.min = pick(w, m, `AODT_UD_RB, `AODT_UD_RW,
                    `AODT_UD_MB, `AODT_UD_MW);
                o_timing.max = o_timing.min;
            end
            aodt_pkg::op_signed_divide: begin
                o_timing.min = pick(w, m, `AODT_SD_RB_MIN, `AODT_SD_RW_MIN,
                    `AODT_SD_MB_MIN, `AODT_SD_MW_MIN);
                o_timing.max = pick(w, m, `AODT_SD_RB_MAX, `AODT_SD_RW_MAX,
                    `AODT_SD_MB_MAX, `AODT_SD_MW_MAX);
            end
            default: begin
                o_timing.min = `AODT_ONE;
                o_timing.max = `AODT_ONE;
            end
        endcase
    end

endmodule // aodt_cycle_table

// [rtl/aodt_decoder.sv]
`timescale 1ns/10ps
`include "aodt_consts.svh"

module aodt_decoder (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bus8,
    input wire logic i_instr_valid,
    input wire aodt_pkg::aodt_instr_t i_instr,
    output logic o_instr_ready,
    output aodt_pkg::aodt_decode_t o_decode,
    output aodt_pkg::aodt_timing_t o_timing,
    output logic o_busy,
    output logic o_done,
    output logic o_bus8
);

    // ****************************************************************
    // Helper functions.
    // ****************************************************************

    function automatic logic [2:0] reg_field(input logic [7:0] modrm);
        reg_field = modrm[`AODT_REG_MSB:`AODT_REG_LSB];
    endfunction

    function automatic logic is_memory(input logic [7:0] modrm);
        is_memory = (modrm[`AODT_MOD_MSB:`AODT_MOD_LSB] != `AODT_MOD_REG);
    endfunction

    function automatic logic is_shift(input logic [7:0] opcode);
        logic [6:0] top;
        top = opcode[7:1];
        is_shift = (top == `AODT_OPC_SH_ONE) ||
            (top == `AODT_OPC_SH_CL) ||
            (top == `AODT_OPC_SH_CNT);
    endfunction

    // ****************************************************************
    // Bus width strap synchroniser.
    // ****************************************************************

    logic bus8_s1;
    logic bus8_s2;
    logic bus8_s3;
    logic bus8;
    logic next_bus8;

    always_comb begin
        next_bus8 = bus8;
        if (bus8_s2 == bus8_s3) begin
            next_bus8 = bus8_s3;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus8_s1 <= 1'b0;
            bus8_s2 <= 1'b0;
            bus8_s3 <= 1'b0;
            bus8 <= 1'b0;
        end else begin
            bus8_s1 <= i_bus8;
            bus8_s2 <= bus8_s1;
            bus8_s3 <= bus8_s2;
            bus8 <= next_bus8;
        end
    end

    assign o_bus8 = bus8;

    // ****************************************************************
    // Opcode decode.
    // ****************************************************************

    aodt_pkg::aodt_decode_t dec;
    logic [7:0] opc;
    logic [7:0] mrm;
    logic [2:0] rf;

    assign opc = i_instr.opcode;
    assign mrm = i_instr.modrm;
    assign rf = reg_field(i_instr.modrm);

    always_comb begin
        dec.op = aodt_pkg::op_none;
        dec.shift = aodt_pkg::sh_none;
        dec.word = opc[`AODT_W_BIT];
        dec.mem = 1'b0;
        dec.has_modrm = 1'b0;
        dec.imm_bytes = 2'h0;
        dec.illegal = 1'b0;
        if (opc[7:1] == `AODT_OPC_GRP3) begin
            dec.has_modrm = 1'b1;
            dec.mem = is_memory(mrm);
            unique case (rf)
                `AODT_REG_NEGATE: begin
                    dec.op = aodt_pkg::op_negate_operand;
                end
                `AODT_REG_UMUL: begin
                    dec.op = aodt_pkg::op_unsigned_multiply;
                end
                `AODT_REG_SMUL: begin
                    dec.op = aodt_pkg::op_signed_multiply;
                end
                `AODT_REG_UDIVIDE: begin
                    dec.op = aodt_pkg::op_unsigned_divide;
                end
                `AODT_REG_SDIVIDE: begin
                    dec.op = aodt_pkg::op_signed_divide;
                end
                default: begin
                    dec.op = aodt_pkg::op_none;
                end
            endcase
        end else if (opc[7:2] == `AODT_OPC_IMMUL && opc[0]) begin
            dec.op = aodt_pkg::op_signed_multiply_imm;
            dec.word = 1'b1;
            dec.has_modrm = 1'b1;
            dec.mem = is_memory(mrm);
            // One data byte when sign extended, two otherwise.
            dec.imm_bytes = opc[`AODT_S_BIT] ? 2'h1 : 2'h2;
        end else if (opc == `AODT_OPC_AAA) begin
            dec.op = aodt_pkg::op_ascii_adjust_after_add;
            dec.word = 1'b0;
        end else if (opc == `AODT_OPC_DAA) begin
            dec.op = aodt_pkg::op_decimal_adjust_after_add;
            dec.word = 1'b0;
        end else if (opc == `AODT_OPC_AAS) begin
            dec.op = aodt_pkg::op_ascii_adjust_after_sub;
            dec.word = 1'b0;
        end else if (opc == `AODT_OPC_DAS) begin
            dec.op = aodt_pkg::op_decimal_adjust_after_sub;
            dec.word = 1'b0;
        end else if (is_shift(opc)) begin
            dec.op = aodt_pkg::op_shift_rotate;
            dec.has_modrm = 1'b1;
            dec.mem = is_memory(mrm);
            dec.imm_bytes = (opc[7:1] == `AODT_OPC_SH_CNT) ? 2'h1 : 2'h0;
            unique case (rf)
                3'h0: dec.shift = aodt_pkg::sh_rotate_left;
                3'h1: dec.shift = aodt_pkg::sh_rotate_right;
                3'h2: dec.shift = aodt_pkg::sh_rotate_carry_left;
                3'h3: dec.shift = aodt_pkg::sh_rotate_carry_right;
                3'h4: dec.shift = aodt_pkg::sh_shift_left;
                3'h5: dec.shift = aodt_pkg::sh_shift_right_logic;
                3'h7: dec.shift = aodt_pkg::sh_shift_right_arith;
                default: begin
                    dec.shift = aodt_pkg::sh_none;
                    dec.illegal = 1'b1;
                end
            endcase
        end else begin
            dec.word = 1'b0;
        end
        if (dec.op == aodt_pkg::op_none && opc[7:1] == `AODT_OPC_GRP3) begin
            dec.illegal = 1'b0;
        end
    end

    // ****************************************************************
    // Cycle table.
    // ****************************************************************

    aodt_pkg::aodt_timing_t tim;

    aodt_cycle_table u_table (
        .i_decode(dec),
        .i_bus8(bus8),
        .o_timing(tim)
    );

    // ****************************************************************
    // Execution sequencer.
    // ****************************************************************

    typedef enum logic {
        st_idle,
        st_exec
    } aodt_state_t;

    aodt_state_t state;
    aodt_state_t next_state;
    logic [`AODT_CYC_W-1:0] count;
    logic [`AODT_CYC_W-1:0] next_count;
    aodt_pkg::aodt_decode_t decode;
    aodt_pkg::aodt_decode_t next_decode;
    aodt_pkg::aodt_timing_t timing;
    aodt_pkg::aodt_timing_t next_timing;
    logic done;
    logic next_done;
    logic take;

    assign take = i_instr_valid && (state == st_idle);

    always_comb begin
        next_state = state;
        next_count = count;
        next_decode = decode;
        next_timing = timing;
        next_done = 1'b0;
        unique case (state)
            st_idle: begin
                if (take) begin
                    next_decode = dec;
                    next_timing = tim;
                    // Worst case cycle count is spent.
                    next_count = tim.max;
                    next_state = st_exec;
                end
            end
            st_exec: begin
                if (count == `AODT_ONE) begin
                    next_done = 1'b1;
                    next_state = st_idle;
                    next_count = 7'h00;
                end else begin
                    next_count = count - `AODT_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= st_idle;
            count <= 7'h00;
            decode <= '0;
            timing <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            decode <= next_decode;
            timing <= next_timing;
            done <= next_done;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    assign o_instr_ready = (state == st_idle);
    assign o_busy = (state == st_exec);
    assign o_done = done;
    assign o_decode = decode;
    assign o_timing = timing;

endmodule // aodt_decoder

// [dv/aodt_decoder_sva.sv]
`timescale 1ns/10ps

module aodt_decoder_chk (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_bus8,
    input wire logic i_instr_valid,
    input wire aodt_pkg::aodt_instr_t i_instr,
    input wire logic o_instr_ready,
    input wire aodt_pkg::aodt_decode_t o_decode,
    input wire aodt_pkg::aodt_timing_t o_timing,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_bus8
);
    logic take;
    logic grp;
    logic rr;
    logic [2:0] rf;
    assign take = i_instr_valid & o_instr_ready;
    assign grp = take & (i_instr.opcode[7:1] == 7'h7b);
    assign rf = i_instr.modrm[5:3];
    assign rr = (i_instr.modrm[7:6] == 2'h3);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // **********
    // Timing and decode checks.
    // **********
    AST_NEG_REG: assert property (grp && rf == 3'h3 && rr |=>
        o_busy [*3] ##1 (o_done && !o_busy)) else $error("negate reg length");
    AST_NEG_MEM: assert property (grp && rf == 3'h3 && !rr &&
        !i_instr.opcode[0] |=> o_timing.max == 7'h0a) else $error("negate mem");
    AST_ADD_ASCII: assert property (take && i_instr.opcode == 8'h37 |=>
        o_busy [*8] ##1 o_done) else $error("ascii add length");
    AST_ADD_DEC: assert property (take && i_instr.opcode == 8'h27 |=>
        (o_busy && o_timing.max == 7'h04) [*4] ##1 o_done)
        else $error("decimal add length");
    AST_SUB_ASCII: assert property (take && i_instr.opcode == 8'h3f |=>
        o_busy [*7] ##1 o_done) else $error("ascii sub length");
    AST_SUB_DEC: assert property (take && i_instr.opcode == 8'h2f |=>
        o_decode.op == aodt_pkg::op_decimal_adjust_after_sub &&
        o_timing.max == 7'h04) else $error("decimal sub");
    AST_UMUL_RB: assert property (grp && rf == 3'h4 && rr &&
        !i_instr.opcode[0] |=> o_timing.min == 7'h1a && o_timing.max == 7'h1c)
        else $error("unsigned multiply timing");
    AST_SMUL_RB: assert property (grp && rf == 3'h5 && rr &&
        !i_instr.opcode[0] |=> o_timing.min == 7'h19 && o_timing.max == 7'h1c)
        else $error("signed multiply timing");
    AST_IMM_LEN: assert property (take && i_instr.opcode[7:2] == 6'h1a &&
        i_instr.opcode[0] |=> o_decode.imm_bytes ==
        ($past(i_instr.opcode[1]) ? 2'h1 : 2'h2)) else $error("imm count");
    AST_SDIV_SEL: assert property (grp && rf == 3'h7 |=>
        o_decode.op == aodt_pkg::op_signed_divide) else $error("divide sel");
    AST_WORD_XFER: assert property (grp && rf == 3'h3 && !rr &&
        i_instr.opcode[0] && o_bus8 |=> o_timing.max == 7'h12)
        else $error("word transfer extra");
    AST_SHIFT_ARITH: assert property (take && rf == 3'h7 &&
        i_instr.opcode[7:1] == 7'h68 |=>
        o_decode.shift == aodt_pkg::sh_shift_right_arith) else $error("shift");
    AST_WORD_BIT: assert property (grp |=>
        o_decode.word == $past(i_instr.opcode[0])) else $error("word bit");
    AST_UDIV_RB: assert property (grp && rf == 3'h6 && rr &&
        !i_instr.opcode[0] |=> o_timing.max == 7'h1d) else $error("udiv");

    cover property (take ##1 o_busy);
    cover property (o_done && take);
    cover property (o_bus8 && take);
endmodule // aodt_decoder_chk

bind aodt_decoder aodt_decoder_chk u_chk (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_bus8(i_bus8),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .o_instr_ready(o_instr_ready),
    .o_decode(o_decode),
    .o_timing(o_timing),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_bus8(o_bus8)
);

// [dv/arith_opcode_decode_timing_test.sv]
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
    n_errors++; $display("CHECK FAILED t=%0t %s", $time, m); end end

module arith_opcode_decode_timing_test;
    typedef struct packed {
        aodt_pkg::aodt_op_t op;
        aodt_pkg::aodt_shift_t sh;
        logic word;
        logic mem;
        logic ill;
        logic hm;
        logic chkt;
        logic [1:0] imm;
        logic [6:0] min;
        logic [6:0] max;
    } aodt_exp_t;

    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_bus8 = 1'b0;
    logic i_instr_valid = 1'b0;
    aodt_pkg::aodt_instr_t i_instr = '0;
    logic o_instr_ready;
    logic o_busy;
    logic o_done;
    logic o_bus8;
    aodt_pkg::aodt_decode_t o_decode;
    aodt_pkg::aodt_timing_t o_timing;
    aodt_exp_t exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    int n_busy = 0;

    always #12.5 i_clock = ~i_clock;

    aodt_decoder DUT (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_bus8(i_bus8),
        .i_instr_valid(i_instr_valid),
        .i_instr(i_instr),
        .o_instr_ready(o_instr_ready),
        .o_decode(o_decode),
        .o_timing(o_timing),
        .o_busy(o_busy),
        .o_done(o_done),
        .o_bus8(o_bus8)
    );

    // **********
    // Driver tasks.
    // **********
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic issue(input logic [7:0] opc, input logic [7:0] mrm,
                         input aodt_exp_t e);
        int k;
        k = 0;
        exp_q.push_back(e);
        i_instr <= {opc, mrm};
        i_instr_valid <= 1'b1;
        @(negedge i_clock);
        while (o_instr_ready !== 1'b1 && k < 200) begin
            @(negedge i_clock);
            k++;
        end
        if (k == 200) begin
            n_errors++;
            $display("CHECK FAILED t=%0t ready timeout", $time);
        end
        @(posedge i_clock);
    endtask

    task automatic run(input logic [7:0] opc, input logic [7:0] mrm,
                       input aodt_pkg::aodt_op_t op,
                       input logic [6:0] mn, input logic [6:0] mx);
        aodt_exp_t e;
        logic adj;
        adj = (opc[7:6] == 2'h0);
        e = '0;
        e.op = op;
        e.word = adj ? 1'b0 : opc[0];
        e.mem = adj ? 1'b0 : (mrm[7:6] != 2'h3);
        e.imm = (opc[7:2] == 6'h1a) ? (opc[1] ? 2'h1 : 2'h2) : 2'h0;
        e.hm = !adj;
        e.chkt = 1'b1;
        e.min = mn;
        e.max = mx;
        issue(opc, adj ? mrm : {mrm[7:3], 3'($urandom)}, e);
    endtask

    task automatic drain();
        i_instr_valid <= 1'b0;
        for (int k = 0; k < 300 && exp_q.size() != 0; k++)
            @(negedge i_clock);
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("CHECK FAILED t=%0t drain timeout", $time);
        end
        @(posedge i_clock);
    endtask

    // **********
    // Result monitor.
    // **********
    always @(negedge i_clock) begin : mon
        aodt_exp_t e;
        if (o_busy === 1'b1)
            n_busy++;
        if (o_done === 1'b1 && exp_q.size() == 0) begin
            n_errors++;
            $display("CHECK FAILED t=%0t done without request", $time);
        end else if (o_done === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(o_decode.op, e.op, "op")
            `CHK(o_decode.word, e.word, "word")
            `CHK(o_decode.mem, e.mem, "mem")
            `CHK(o_decode.imm_bytes, e.imm, "imm")
            `CHK(o_decode.illegal, e.ill, "illegal")
            `CHK(o_decode.has_modrm, e.hm, "modrm")
            if (e.op == aodt_pkg::op_shift_rotate && !e.ill)
                `CHK(o_decode.shift, e.sh, "shift")
            if (e.chkt) begin
                `CHK(o_timing.min, e.min, "min")
                `CHK(o_timing.max, e.max, "max")
                `CHK(n_busy, int'(e.max), "cycles")
            end
            n_busy = 0;
        end
    end

    // **********
    // Main sequence.
    // **********
    initial begin : main
        aodt_exp_t e;
        logic [7:0] m;
        logic [7:0] o;
        void'($urandom(32'hcdd6));
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        run(8'hf7, 8'hd8, aodt_pkg::op_negate_operand, 7'h03, 7'h03);
        run(8'hf6, 8'h1e, aodt_pkg::op_negate_operand, 7'h0a, 7'h0a);
        run(8'hf7, 8'h1e, aodt_pkg::op_negate_operand, 7'h0a, 7'h0a);
        run(8'h37, 8'hc0, aodt_pkg::op_ascii_adjust_after_add, 7'h08, 7'h08);
        run(8'h27, 8'hc0, aodt_pkg::op_decimal_adjust_after_add, 7'h04, 7'h04);
        run(8'h3f, 8'hc0, aodt_pkg::op_ascii_adjust_after_sub, 7'h07, 7'h07);
        run(8'h2f, 8'hc0, aodt_pkg::op_decimal_adjust_after_sub, 7'h04, 7'h04);
        run(8'hf6, 8'he0, aodt_pkg::op_unsigned_multiply, 7'h1a, 7'h1c);
        run(8'hf7, 8'he0, aodt_pkg::op_unsigned_multiply, 7'h23, 7'h25);
        run(8'hf6, 8'h26, aodt_pkg::op_unsigned_multiply, 7'h20, 7'h22);
        run(8'hf7, 8'h26, aodt_pkg::op_unsigned_multiply, 7'h29, 7'h2b);
        run(8'hf6, 8'he8, aodt_pkg::op_signed_multiply, 7'h19, 7'h1c);
        run(8'hf7, 8'he8, aodt_pkg::op_signed_multiply, 7'h22, 7'h25);
        run(8'hf6, 8'h2e, aodt_pkg::op_signed_multiply, 7'h1f, 7'h22);
        run(8'hf7, 8'h2e, aodt_pkg::op_signed_multiply, 7'h28, 7'h2b);
        run(8'h69, 8'hc0, aodt_pkg::op_signed_multiply_imm, 7'h16, 7'h19);
        run(8'h6b, 8'h06, aodt_pkg::op_signed_multiply_imm, 7'h1d, 7'h20);
        run(8'hf6, 8'hf0, aodt_pkg::op_unsigned_divide, 7'h1d, 7'h1d);
        run(8'hf7, 8'hf0, aodt_pkg::op_unsigned_divide, 7'h26, 7'h26);
        run(8'hf6, 8'h36, aodt_pkg::op_unsigned_divide, 7'h23, 7'h23);
        run(8'hf7, 8'h36, aodt_pkg::op_unsigned_divide, 7'h2c, 7'h2c);
        run(8'hf6, 8'hf8, aodt_pkg::op_signed_divide, 7'h2c, 7'h34);
        run(8'hf7, 8'h3e, aodt_pkg::op_signed_divide, 7'h3b, 7'h43);
        run(8'hf6, 8'hc8, aodt_pkg::op_none, 7'h01, 7'h01);
        for (int r = 0; r < 8; r++) begin
            e = '0;
            e.op = aodt_pkg::op_shift_rotate;
            e.sh = aodt_pkg::aodt_shift_t'((r == 7) ? 7 : r + 1);
            e.ill = (r == 6);
            m = 8'($urandom);
            m[5:3] = 3'(r);
            o = (r % 3 == 2) ? 8'hc0 : ((r % 3 == 1) ? 8'hd0 : 8'hd2);
            o[0] = 1'($urandom_range(0, 1));
            e.imm = (o[7:1] == 7'h60) ? 2'h1 : 2'h0;
            e.hm = 1'b1;
            e.chkt = 1'b1;
            e.min = 7'h01;
            e.max = 7'h01;
            e.word = o[0];
            e.mem = (m[7:6] != 2'h3);
            issue(o, m, e);
        end
        drain();
        i_bus8 <= 1'b1;
        repeat (6) @(negedge i_clock);
        `CHK(o_bus8, 1'b1, "strap")
        @(posedge i_clock);
        run(8'hf7, 8'h26, aodt_pkg::op_unsigned_multiply, 7'h29, 7'h30);
        run(8'hf6, 8'h2e, aodt_pkg::op_signed_multiply, 7'h20, 7'h22);
        run(8'hf7, 8'h1e, aodt_pkg::op_negate_operand, 7'h12, 7'h12);
        run(8'hf6, 8'h1e, aodt_pkg::op_negate_operand, 7'h0a, 7'h0a);
        run(8'hf7, 8'he0, aodt_pkg::op_unsigned_multiply, 7'h23, 7'h25);
        run(8'h6b, 8'h06, aodt_pkg::op_signed_multiply_imm, 7'h21, 7'h24);
        drain();
        give_verdict();
    end

    initial begin : watchdog
        #(25 * 20000);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        give_verdict();
    end
endmodule // arith_opcode_decode_timing_test
